//--- rtl/scrt_timer.sv
// scrt_timer: 16-bit capture/reload/baud timer with its two control registers.
// assumes a single core clock, a strobe register port and asynchronous pins.
//
// Overview of operation
// RULE_01 - overflow sets the overflow flag; it stays until software writes zero
// RULE_02 - rollover leaves overflow flag alone while either baud select is one
// RULE_03 - trigger falling edge causing capture or reload sets external flag when enabled
// RULE_04 - external flag requests the shared counter interrupt like the overflow flag
// RULE_05 - only software clears the external flag; hardware never does (here up/down overflow or underflow toggles it)
// RULE_06 - with down count enabled the external flag raises no interrupt
// RULE_07 - receive baud select picks this counter's overflow, else other timer's
// RULE_08 - transmit baud select picks this counter's overflow, else other timer's
// RULE_09 - run control one counts, zero holds the count
// RULE_10 - source select zero counts machine cycles, osc/12 or osc/6
// RULE_11 - source select one counts falling edges of the external count input
// RULE_12 - capture mode with trigger enable copies count on trigger falling edge
// RULE_13 - reload mode reloads on overflow, and on trigger edge if enabled
// RULE_14 - either baud select forces auto-reload on overflow, capture select ignored
// RULE_15 - baud mode trigger edge sets external flag but does not reload
// RULE_16 - down count enable allows up/down counting
// RULE_17 - up/down reload mode counts up with trigger high, down with it low
// RULE_18 - software should not write ones to reserved mode bits
// RULE_19 - reserved mode bits read as undefined; here they read zero
// RULE_20 - pin falling edges found by sampling on the core clock
`timescale 1ns/100ps
module scrt_timer
(
   input wire logic CLK_I,
   input wire logic RST_N_I,
   input wire scrt_pkg::scrt_req_t REQ_I,
   output logic [7:0] RDATA_O,
   input wire logic SIX_CLK_MODE_I,
   input wire logic COUNT_PIN_I,
   input wire logic TRIGGER_PIN_I,
   input wire logic OTHER_OVF_I,
   output logic IRQ_O,
   output scrt_pkg::scrt_baud_t BAUD_O,
   output logic CLKOUT_EN_O
);
   import scrt_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [7:0] ctrl_r;
   logic [1:0] mode_r;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic [15:0] rel_r;
   logic [SCRT_PRE_W-1:0] pre_r;
   logic [7:0] rdata_r;
   logic ovf_pulse_r;
   logic trig_lvl;
   logic trig_fall;
   logic cnt_fall;
   logic tick;
   logic baud_mode;
   logic capture_mode;
   logic up_down;
   logic overflow;
   logic underflow;
   logic trig_reload;
   logic ext_event;
   logic [SCRT_PRE_W-1:0] div_sel;

   function automatic logic wr_hit(input scrt_req_t r, input logic [7:0] off);
      wr_hit = r.wr && (r.addr == off);
   endfunction

   // ------------------------------------------------------------
   // pin edge detection
   // ------------------------------------------------------------
   scrt_fall_det u_trig
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .pin_i(TRIGGER_PIN_I),
      .level_o(trig_lvl),
      .fall_o(trig_fall)
   );

   scrt_fall_det u_cnt
   (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .pin_i(COUNT_PIN_I),
      .level_o(),
      .fall_o(cnt_fall)
   );

   // ------------------------------------------------------------
   // mode decode
   // ------------------------------------------------------------
   assign baud_mode = ctrl_r[SCRT_B_RXB] | ctrl_r[SCRT_B_TXB];
   assign capture_mode = ctrl_r[SCRT_B_CAP] & ~baud_mode; // [RULE_14]
   assign up_down = mode_r[SCRT_B_DCE] & ~capture_mode & ~baud_mode; // [RULE_16]

   // baud timing counts faster than a machine cycle, as the serial path expects
   always_comb
   begin
      if (baud_mode)
         div_sel = SIX_CLK_MODE_I ? SCRT_PRE_W'(SCRT_BAUD6_DIV) : SCRT_PRE_W'(SCRT_BAUD12_DIV);
      else
         div_sel = SIX_CLK_MODE_I ? SCRT_PRE_W'(SCRT_MC6_DIV) : SCRT_PRE_W'(SCRT_MC12_DIV); // [RULE_10]
   end

   // ------------------------------------------------------------
   // prescaler: one core clock stands in for one oscillator period
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         pre_r <= '0;
      else if (!ctrl_r[SCRT_B_RUN] || pre_r >= div_sel - SCRT_PRE_W'(1))
         pre_r <= '0;
      else
         pre_r <= pre_r + SCRT_PRE_W'(1);
   end

   assign tick = ctrl_r[SCRT_B_RUN] &
                 (ctrl_r[SCRT_B_SRC] ? cnt_fall : (pre_r >= div_sel - SCRT_PRE_W'(1))); // [RULE_09] [RULE_11]

   // ------------------------------------------------------------
   // counter
   // ------------------------------------------------------------
   assign overflow = tick & (!up_down | trig_lvl) & (cnt_r == SCRT_CNT_MAX);
   assign underflow = tick & up_down & !trig_lvl & (cnt_r == rel_r);
   // trigger edges reload only in plain reload mode without up/down direction use
   assign trig_reload = trig_fall & ctrl_r[SCRT_B_TEN] & !capture_mode & !baud_mode & !up_down; // [RULE_13] [RULE_15]
   assign ext_event = trig_fall & ctrl_r[SCRT_B_TEN] & !up_down; // [RULE_03] [RULE_15]

   always_comb
   begin
      cnt_nxt = cnt_r;
      if (trig_reload)
         cnt_nxt = rel_r; // [RULE_13]
      else if (overflow && !capture_mode)
         cnt_nxt = rel_r; // [RULE_13] [RULE_14]
      else if (underflow)
         cnt_nxt = SCRT_CNT_MAX;
      else if (tick && up_down && !trig_lvl)
         cnt_nxt = cnt_r - 16'h0001; // [RULE_17]
      else if (tick)
         cnt_nxt = cnt_r + 16'h0001;
   end

   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         cnt_r <= SCRT_ZERO16;
      else if (wr_hit(REQ_I, SCRT_OFF_CNTL))
         cnt_r <= {cnt_nxt[15:8], REQ_I.wdata};
      else if (wr_hit(REQ_I, SCRT_OFF_CNTH))
         cnt_r <= {REQ_I.wdata, cnt_nxt[7:0]};
      else
         cnt_r <= cnt_nxt;
   end

   // capture wins over a software write in the same cycle
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rel_r <= SCRT_ZERO16;
      else if (trig_fall && ctrl_r[SCRT_B_TEN] && capture_mode)
         rel_r <= cnt_r; // [RULE_12]
      else if (wr_hit(REQ_I, SCRT_OFF_RELL))
         rel_r <= {rel_r[15:8], REQ_I.wdata};
      else if (wr_hit(REQ_I, SCRT_OFF_RELH))
         rel_r <= {REQ_I.wdata, rel_r[7:0]};
   end

   // ------------------------------------------------------------
   // control registers; hardware set beats software clear
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         ctrl_r <= SCRT_CTRL_RST;
      else
      begin
         if (wr_hit(REQ_I, SCRT_OFF_CTRL))
            ctrl_r <= REQ_I.wdata;
         if ((overflow || underflow) && !baud_mode)
            ctrl_r[SCRT_B_OVF] <= 1'b1; // [RULE_01] [RULE_02]
         if (ext_event)
            ctrl_r[SCRT_B_EXT] <= 1'b1; // [RULE_03] [RULE_05]
         else if ((overflow || underflow) && up_down)
            ctrl_r[SCRT_B_EXT] <= ~ctrl_r[SCRT_B_EXT];
      end
   end

   // reserved bits are not stored at all
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         mode_r <= SCRT_MODE_RST;
      else if (wr_hit(REQ_I, SCRT_OFF_MODE))
         mode_r <= REQ_I.wdata[1:0];
   end

   // ------------------------------------------------------------
   // read port, data one cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         rdata_r <= 8'h00;
      else if (REQ_I.rd)
      begin
         unique case (REQ_I.addr)
            SCRT_OFF_CTRL: rdata_r <= ctrl_r;
            SCRT_OFF_MODE: rdata_r <= {SCRT_MODE_RSVD, mode_r}; // [RULE_19]
            SCRT_OFF_RELL: rdata_r <= rel_r[7:0];
            SCRT_OFF_RELH: rdata_r <= rel_r[15:8];
            SCRT_OFF_CNTL: rdata_r <= cnt_r[7:0];
            SCRT_OFF_CNTH: rdata_r <= cnt_r[15:8];
            default: rdata_r <= 8'h00;
         endcase
      end
      else
         rdata_r <= 8'h00;
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   always_ff @(posedge CLK_I or negedge RST_N_I)
   begin
      if (!RST_N_I)
         ovf_pulse_r <= 1'b0;
      else
         ovf_pulse_r <= overflow && baud_mode;
   end

   assign RDATA_O = rdata_r;
   assign IRQ_O = ctrl_r[SCRT_B_OVF] | (ctrl_r[SCRT_B_EXT] & ~mode_r[SCRT_B_DCE]); // [RULE_04] [RULE_06]
   assign BAUD_O.rx_tick = ctrl_r[SCRT_B_RXB] ? ovf_pulse_r : OTHER_OVF_I; // [RULE_07]
   assign BAUD_O.tx_tick = ctrl_r[SCRT_B_TXB] ? ovf_pulse_r : OTHER_OVF_I; // [RULE_08]
   assign CLKOUT_EN_O = mode_r[SCRT_B_OE];

   // ------------------------------------------------------------
   // checks: flags and interrupt
   // ------------------------------------------------------------
   ovf_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_01]
      (overflow && !baud_mode) |=> ctrl_r[SCRT_B_OVF]) else $error("overflow flag not set");
   ovf_sticky_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_01]
      (ctrl_r[SCRT_B_OVF] && !wr_hit(REQ_I, SCRT_OFF_CTRL)) |=> ctrl_r[SCRT_B_OVF])
      else $error("overflow flag dropped");
   baud_noovf_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_02]
      (baud_mode && !ctrl_r[SCRT_B_OVF] && !wr_hit(REQ_I, SCRT_OFF_CTRL)) |=> !ctrl_r[SCRT_B_OVF])
      else $error("overflow flag set in baud mode");
   ext_sets_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_03]
      ext_event |=> ctrl_r[SCRT_B_EXT]) else $error("external flag not set");
   // only the up/down toggle may clear the external flag without software
   ext_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_05]
      (ctrl_r[SCRT_B_EXT] && !up_down && !wr_hit(REQ_I, SCRT_OFF_CTRL)) |=> ctrl_r[SCRT_B_EXT])
      else $error("external flag dropped");
   irq_ovf_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_04]
      ctrl_r[SCRT_B_OVF] |-> IRQ_O) else $error("overflow flag no irq");
   irq_ext_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_04]
      (ctrl_r[SCRT_B_EXT] && !mode_r[SCRT_B_DCE]) |-> IRQ_O) else $error("external flag no irq");
   irq_down_count_enable_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_06]
      (mode_r[SCRT_B_DCE] && !ctrl_r[SCRT_B_OVF]) |-> !IRQ_O) else $error("irq in up/down mode");
   mode_rsvd_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_19]
      (REQ_I.rd && REQ_I.addr == SCRT_OFF_MODE) |=> RDATA_O[7:2] == SCRT_MODE_RSVD)
      else $error("reserved mode bits not zero");

   // ------------------------------------------------------------
   // checks: counting
   // ------------------------------------------------------------
   run_hold_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_09]
      (!ctrl_r[SCRT_B_RUN] && !trig_reload && !REQ_I.wr) |=> cnt_r == $past(cnt_r))
      else $error("count moved while stopped");
   src_tick_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_11]
      (ctrl_r[SCRT_B_RUN] && ctrl_r[SCRT_B_SRC]) |-> tick == cnt_fall) else $error("event tick wrong");
   // machine-cycle ticks come at least 9 clocks apart in 12-clock mode, 6 in 6-clock mode; a mode change releases the check
   mc12_gap_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_10]
      (tick && !ctrl_r[SCRT_B_SRC] && !baud_mode && !SIX_CLK_MODE_I)
      |=> (!tick || ctrl_r[SCRT_B_SRC] || baud_mode || SIX_CLK_MODE_I) [*8])
      else $error("12-clock tick too early");
   mc6_gap_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_10]
      (tick && !ctrl_r[SCRT_B_SRC] && !baud_mode && SIX_CLK_MODE_I)
      |=> (!tick || ctrl_r[SCRT_B_SRC] || baud_mode || !SIX_CLK_MODE_I) [*5])
      else $error("6-clock tick too early");
   capture_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_12]
      (trig_fall && ctrl_r[SCRT_B_TEN] && capture_mode) |=> rel_r == $past(cnt_r))
      else $error("capture missed");
   reload_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_13] [RULE_14]
      (overflow && !capture_mode && !REQ_I.wr) |=> cnt_r == $past(rel_r))
      else $error("reload missed");
   trig_reload_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_13]
      (trig_reload && !REQ_I.wr) |=> cnt_r == $past(rel_r)) else $error("trigger reload missed");
   // in baud mode a trigger edge may only let the count step on as usual
   baud_notrig_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_15]
      (trig_fall && ctrl_r[SCRT_B_TEN] && baud_mode && !overflow && !REQ_I.wr)
      |=> (cnt_r == $past(cnt_r) || cnt_r == $past(cnt_r) + 16'h0001))
      else $error("trigger reloaded in baud mode");
   down_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_17]
      (tick && up_down && !trig_lvl && !underflow && !trig_reload && !REQ_I.wr)
      |=> cnt_r == $past(cnt_r) - 16'h0001) else $error("down count wrong");

   // ------------------------------------------------------------
   // checks: baud tick routing
   // ------------------------------------------------------------
   rx_sel_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_07]
      !ctrl_r[SCRT_B_RXB] |-> BAUD_O.rx_tick == OTHER_OVF_I) else $error("rx baud source wrong");
   tx_sel_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_08]
      !ctrl_r[SCRT_B_TXB] |-> BAUD_O.tx_tick == OTHER_OVF_I) else $error("tx baud source wrong");
   rx_own_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_07]
      (overflow && ctrl_r[SCRT_B_RXB] && !wr_hit(REQ_I, SCRT_OFF_CTRL)) |=> BAUD_O.rx_tick)
      else $error("rx baud tick missing");
   tx_own_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I) // [RULE_08]
      (overflow && ctrl_r[SCRT_B_TXB] && !wr_hit(REQ_I, SCRT_OFF_CTRL)) |=> BAUD_O.tx_tick)
      else $error("tx baud tick missing");
endmodule // scrt_timer

//--- rtl/scrt_pkg.sv
// scrt_pkg: constants and carrier types for the 16-bit capture/reload timer.
// assumes a single 100 MHz core clock and a plain strobe register port.
package scrt_pkg;
   // ------------------------------------------------------------
   // register map (byte addresses on the plain register port)
   // ------------------------------------------------------------
   localparam logic [7:0] SCRT_OFF_CTRL = 8'hc8;
   localparam logic [7:0] SCRT_OFF_MODE = 8'hc9;
   localparam logic [7:0] SCRT_OFF_RELL = 8'hca;
   localparam logic [7:0] SCRT_OFF_RELH = 8'hcb;
   localparam logic [7:0] SCRT_OFF_CNTL = 8'hcc;
   localparam logic [7:0] SCRT_OFF_CNTH = 8'hcd;
   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int SCRT_B_OVF = 7;
   localparam int SCRT_B_EXT = 6;
   localparam int SCRT_B_RXB = 5;
   localparam int SCRT_B_TXB = 4;
   localparam int SCRT_B_TEN = 3;
   localparam int SCRT_B_RUN = 2;
   localparam int SCRT_B_SRC = 1;
   localparam int SCRT_B_CAP = 0;
   localparam int SCRT_B_OE = 1;
   localparam int SCRT_B_DCE = 0;
   localparam logic [7:0] SCRT_CTRL_RST = 8'h00;
   localparam logic [1:0] SCRT_MODE_RST = 2'h0;
   localparam logic [5:0] SCRT_MODE_RSVD = 6'h00;
   localparam logic [15:0] SCRT_CNT_MAX = 16'hffff;
   localparam logic [15:0] SCRT_ZERO16 = 16'h0000;
   // ------------------------------------------------------------
   // timing: machine cycle and baud tick, in core clocks
   // ------------------------------------------------------------
   localparam int SCRT_CLK_MHZ = 100;
   localparam int SCRT_MC12_DIV = 12;
   localparam int SCRT_MC6_DIV = 6;
   localparam int SCRT_BAUD12_DIV = 2;
   localparam int SCRT_BAUD6_DIV = 1;
   localparam int SCRT_PRE_W = 4;
   localparam int SCRT_SYNC_W = 3;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } scrt_req_t;

   typedef struct packed {
      logic rx_tick;
      logic tx_tick;
   } scrt_baud_t;
endpackage

//--- rtl/scrt_fall_det.sv
// scrt_fall_det: synchronises an asynchronous pin and flags its falling edges.
// assumes the pin is unrelated to CLK_I; three stages, decision on stages 2 and 3.
`timescale 1ns/100ps
module scrt_fall_det
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic pin_i,
   output logic level_o,
   output logic fall_o
);
   import scrt_pkg::*;
   logic [SCRT_SYNC_W-1:0] sync_r;
   logic level_r;

   // stage 1 is read only by stage 2 to keep metastability contained
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         sync_r <= '1;
      else
         sync_r <= {sync_r[SCRT_SYNC_W-2:0], pin_i};
   end

   // level changes only once stages 2 and 3 agree
   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         level_r <= 1'b1;
      else if (sync_r[1] == sync_r[2])
         level_r <= sync_r[2];
   end

   assign level_o = level_r;
   assign fall_o = level_r & (sync_r[1] == sync_r[2]) & ~sync_r[2]; // [RULE_20]

   fall_once_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_20]
      fall_o |=> !fall_o) else $error("falling edge flagged twice");
endmodule // scrt_fall_det

//--- tb/scrt_timer_test.sv
// scrt_timer_test: self-checking bench for the 16-bit capture/reload timer.
// assumes the plain strobe register port and pins sampled on the core clock.
`timescale 1ns/100ps
module scrt_timer_test;
   import scrt_pkg::*;
   logic clk_i, rst_n_i, six_i, cnt_pin_i, trg_pin_i, oth_ovf_i, irq_o, clkout_en_o;
   scrt_req_t req_i;
   scrt_baud_t baud_o;
   logic [7:0] rdata_o, b;
   logic [15:0] rv, cv;
   int fails = 0;
   int n_tests = 0;
   int cycles = 0;
   int seed = 32'he82be05a;
   int rx_n, tx_n, ex;
   logic [7:0] cfgs [2] = '{8'h2d, 8'h1d};

   scrt_timer scrt_timer_inst
   (
      .CLK_I(clk_i), .RST_N_I(rst_n_i), .REQ_I(req_i), .RDATA_O(rdata_o), .SIX_CLK_MODE_I(six_i),
      .COUNT_PIN_I(cnt_pin_i), .TRIGGER_PIN_I(trg_pin_i), .OTHER_OVF_I(oth_ovf_i), .IRQ_O(irq_o),
      .BAUD_O(baud_o), .CLKOUT_EN_O(clkout_en_o)
   );

   // ------------------------------------------------------------
   // clock, timeout and shared tasks
   // ------------------------------------------------------------
   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // the whole sequence needs well under 3000 cycles
   always @(posedge clk_i)
   begin
      cycles <= cycles + 1;
      if (cycles == 20000)
      begin
         fails = fails + 1;
         close_out();
      end
   end

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      req_i <= '{addr:a, wdata:d, wr:1'b1, rd:1'b0};
      @(posedge clk_i);
      req_i <= '{addr:a, wdata:d, wr:1'b0, rd:1'b0};
   endtask

   // read data stand only in the cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      req_i <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b1};
      @(posedge clk_i);
      req_i <= '{addr:a, wdata:8'h00, wr:1'b0, rd:1'b0};
      #1;
      d = rdata_o;
   endtask

   task automatic wr16(input logic [7:0] a, input logic [15:0] d);
      wr(a, d[7:0]);
      wr(a + 8'h01, d[15:8]);
   endtask

   task automatic rd16(input logic [7:0] a, output logic [15:0] d);
      rd(a, d[7:0]);
      rd(a + 8'h01, d[15:8]);
   endtask

   function automatic logic [15:0] inr(input logic [15:0] v, input int lo, input int hi);
      return {15'h0000, (int'(v) >= lo) && (int'(v) <= hi)};
   endfunction

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      rst_n_i = 1'b0;
      six_i = 1'b1;
      cnt_pin_i = 1'b1;
      trg_pin_i = 1'b1;
      oth_ovf_i = 1'b0;
      req_i = '{addr:8'h00, wdata:8'h00, wr:1'b0, rd:1'b0};
      repeat (6) @(posedge clk_i);
      rst_n_i <= 1'b1;
      rd(SCRT_OFF_CTRL, b);
      check("ctrl reset", b, SCRT_CTRL_RST);
      rd(8'hc0, b);
      check("unmapped read", b, 8'h00);
      wr(SCRT_OFF_MODE, 8'h02);
      rd(SCRT_OFF_MODE, b);
      check("mode read", b, 8'h02);
      check("output enable", clkout_en_o, 1'b1);
      wr(SCRT_OFF_MODE, 8'h00);
      rv = 16'($random(seed));
      wr16(SCRT_OFF_RELL, rv);
      rd16(SCRT_OFF_RELL, cv);
      check("reload rw", cv, rv);
      // without baud select both ticks follow the other timer
      repeat (16)
      begin
         @(posedge clk_i);
         oth_ovf_i <= 1'($random(seed));
         #1;
         check("rx from other", baud_o.rx_tick, oth_ovf_i);
         check("tx from other", baud_o.tx_tick, oth_ovf_i);
      end
      oth_ovf_i <= 1'b0;
      // machine-cycle rate in both clock modes; run window is 122 clocks
      for (int m = 0; m < 2; m++)
      begin
         six_i <= m[0];
         wr16(SCRT_OFF_CNTL, 16'h0000);
         wr(SCRT_OFF_CTRL, 8'h04);
         repeat (120) @(posedge clk_i);
         wr(SCRT_OFF_CTRL, 8'h00);
         rd16(SCRT_OFF_CNTL, cv);
         ex = 122 / (m ? SCRT_MC6_DIV : SCRT_MC12_DIV);
         check("count rate", inr(cv, ex - 1, ex + 1), 16'h1);
         repeat (30) @(posedge clk_i);
         rd16(SCRT_OFF_CNTL, rv);
         check("stopped holds", rv, cv);
      end
      // overflow in reload mode, flag holds until written to zero
      wr16(SCRT_OFF_RELL, 16'hfffe);
      wr16(SCRT_OFF_CNTL, 16'hfffe);
      wr(SCRT_OFF_CTRL, 8'h04);
      ex = 0;
      while (irq_o !== 1'b1 && ex < 40)
      begin
         @(posedge clk_i);
         #1;
         ex++;
      end
      rd(SCRT_OFF_CTRL, b);
      check("overflow set", b, 8'h84);
      wr(SCRT_OFF_CTRL, 8'h80);
      rd16(SCRT_OFF_CNTL, cv);
      check("reload on overflow", cv, 16'hfffe);
      repeat (20) @(posedge clk_i);
      rd(SCRT_OFF_CTRL, b);
      check("overflow flag", b, 8'h80);
      check("irq overflow", irq_o, 1'b1);
      wr(SCRT_OFF_CTRL, 8'h00);
      #1;
      check("irq cleared", irq_o, 1'b0);
      // baud modes: own overflow drives ticks, no overflow flag, trigger only flags
      for (int i = 0; i < 2; i++)
      begin
         wr16(SCRT_OFF_CNTL, 16'hfffe);
         wr(SCRT_OFF_CTRL, cfgs[i]);
         rx_n = 0;
         tx_n = 0;
         for (int c = 0; c < 40; c++)
         begin
            @(posedge clk_i);
            if (c == 10)
               trg_pin_i <= 1'b0;
            #1;
            rx_n += baud_o.rx_tick;
            tx_n += baud_o.tx_tick;
         end
         rd(SCRT_OFF_CTRL, b);
         check("baud running flags", b, cfgs[i] | 8'h40);
         wr(SCRT_OFF_CTRL, 8'h40);
         rd16(SCRT_OFF_CNTL, cv);
         check("baud no trig reload", inr(cv, 16'hfffe, 16'hffff), 16'h1);
         rd(SCRT_OFF_CTRL, b);
         check("baud flags", b, 8'h40);
         check("irq ext", irq_o, 1'b1);
         check("rx own ticks", rx_n > 0, cfgs[i][5]);
         check("tx own ticks", tx_n > 0, cfgs[i][4]);
         wr(SCRT_OFF_CTRL, 8'h00);
         trg_pin_i <= 1'b1;
      end
      // capture on trigger edge, flag kept, masked by down count enable
      wr16(SCRT_OFF_RELL, 16'h0000);
      wr16(SCRT_OFF_CNTL, 16'h1000);
      wr(SCRT_OFF_CTRL, 8'h0d);
      repeat (30) @(posedge clk_i);
      trg_pin_i <= 1'b0;
      repeat (20) @(posedge clk_i);
      rd(SCRT_OFF_CTRL, b);
      check("capture running flags", b, 8'h4d);
      wr(SCRT_OFF_CTRL, 8'h40);
      rd16(SCRT_OFF_CNTL, cv);
      rd16(SCRT_OFF_RELL, rv);
      check("capture value", {15'h0000, (rv > 16'h1000) && (rv <= cv)}, 16'h1);
      rd(SCRT_OFF_CTRL, b);
      check("ext flag kept", b, 8'h40);
      wr(SCRT_OFF_MODE, 8'h01);
      #1;
      check("ext irq masked", irq_o, 1'b0);
      wr(SCRT_OFF_MODE, 8'h00);
      #1;
      check("ext irq", irq_o, 1'b1);
      // reload on trigger edge in reload mode
      trg_pin_i <= 1'b1;
      wr16(SCRT_OFF_RELL, 16'h1234);
      wr16(SCRT_OFF_CNTL, 16'h0000);
      wr(SCRT_OFF_CTRL, 8'h0c);
      repeat (10) @(posedge clk_i);
      trg_pin_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      rd(SCRT_OFF_CTRL, b);
      check("trigger flag", b, 8'h4c);
      wr(SCRT_OFF_CTRL, 8'h00);
      rd16(SCRT_OFF_CNTL, cv);
      check("trigger reload", inr(cv, 16'h1234, 16'h1236), 16'h1);
      // up/down: trigger low counts down
      wr(SCRT_OFF_MODE, 8'h01);
      wr16(SCRT_OFF_RELL, 16'h0000);
      wr16(SCRT_OFF_CNTL, 16'h0100);
      wr(SCRT_OFF_CTRL, 8'h04);
      repeat (58) @(posedge clk_i);
      wr(SCRT_OFF_CTRL, 8'h00);
      rd16(SCRT_OFF_CNTL, cv);
      check("count down", inr(cv, 16'h0100 - 11, 16'h0100 - 9), 16'h1);
      wr(SCRT_OFF_MODE, 8'h00);
      trg_pin_i <= 1'b1;
      // external event counting
      wr16(SCRT_OFF_CNTL, 16'h0000);
      wr(SCRT_OFF_CTRL, 8'h06);
      repeat (5)
      begin
         repeat (6) @(posedge clk_i);
         cnt_pin_i <= 1'b0;
         repeat (6) @(posedge clk_i);
         cnt_pin_i <= 1'b1;
      end
      repeat (8) @(posedge clk_i);
      wr(SCRT_OFF_CTRL, 8'h00);
      rd16(SCRT_OFF_CNTL, cv);
      check("event count", cv, 16'h0005);
      close_out();
   end
endmodule // scrt_timer_test
